// *** logic/pbmc_regs.vh ***
`ifndef PBMC_REGS_VH
`define PBMC_REGS_VH

// ***************************************************************
// Row map
// ***************************************************************
`define PBMC_ROW_W 11
`define PBMC_CLIP_FIRST 11'h000
`define PBMC_CLIP_LAST 11'h00f
`define PBMC_CLIP_ROWS 11'h004
`define PBMC_MSG_FIRST 11'h010
`define PBMC_LAST_ROW_MIN 11'h0ff
`define PBMC_LAST_ROW_MAX 11'h78f
`define PBMC_MSG_MAX 8

// ***************************************************************
// Timing
// ***************************************************************
`define PBMC_CLK_HZ 40000000
`define PBMC_ROW_TIME_US 125000
`define PBMC_ROW_CYCLES ((`PBMC_CLK_HZ / 1000000) * `PBMC_ROW_TIME_US)
`define PBMC_DEB_TIME_US 20000
`define PBMC_DEB_CYCLES ((`PBMC_CLK_HZ / 1000000) * `PBMC_DEB_TIME_US)
`define PBMC_GERASE_TIME_S 3
`define PBMC_GERASE_CYCLES (`PBMC_CLK_HZ * `PBMC_GERASE_TIME_S + 1)

`endif

// *** logic/pbmc_ctrl.v ***
// How it works
// - Play pulse while idle starts current message.
// - Playback ends at message last row.
// - Play pulse during playback stops it.
// - Play held low loops messages sequentially.
// - Record runs while capture trigger stays low.
// - Capture debounced at start; others both edges.
// - Erase only at first or last message.
// - Short erase pulse deletes current message.
// - Erase held over three seconds erases all.
// - Skip while idle advances pointer only.
// - Skip during playback advances and replays.
// - Ready low while busy in push-button mode.
// - Serial mode: low interrupt until cleared.
// - Storage addressed by 11-bit whole rows.
// - Rows 0x000-0x00F hold four sound clips.
// - Messages start at row 0x010.
// - Last row is a capacity parameter.
// - Message placement managed internally.
// - Exactly one of two operating modes.
// - State machine sets audio path per operation.
`timescale 1ns/100ps
`include "pbmc_regs.vh"

module pbmc_ctrl #(
  parameter [10:0] LAST_ROW = `PBMC_LAST_ROW_MIN,
  parameter integer DEB_CYCLES = `PBMC_DEB_CYCLES,
  parameter integer ROW_CYCLES = `PBMC_ROW_CYCLES,
  parameter integer GERASE_CYCLES = `PBMC_GERASE_CYCLES
) (
  input wire ref_clk,
  input wire srst,
  input wire serial_mode,
  input wire play_trigger_n,
  input wire capture_trigger_n,
  input wire erase_trigger_n,
  input wire skip_next_trigger_n,
  input wire cmd_done,
  input wire int_clear,
  output reg ready_oe,
  output reg ready_o,
  output reg [10:0] row_addr,
  output reg row_write,
  output reg row_erase,
  output reg audio_play,
  output reg audio_record
);

  // ***************************************************************
  // States
  // ***************************************************************
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_PLAY = 5'h02;
  localparam [4:0] ST_REC = 5'h04;
  localparam [4:0] ST_ERASE = 5'h08;
  localparam [4:0] ST_FWD = 5'h10;

  // ***************************************************************
  // Input synchronisers and debounce filters
  // ***************************************************************
  wire [3:0] raw_n = {skip_next_trigger_n, erase_trigger_n, capture_trigger_n, play_trigger_n};
  reg [3:0] sync1;
  reg [3:0] sync2;
  reg [3:0] sync3;
  wire [3:0] pressed;
  reg [3:0] pressed_q;
  wire [3:0] press_edge = pressed & ~pressed_q;
  wire [3:0] release_edge = ~pressed & pressed_q;

  always @(posedge ref_clk) begin
    if (srst) begin
      sync1 <= 4'hf;
      sync2 <= 4'hf;
      sync3 <= 4'hf;
      pressed_q <= 4'h0;
    end else begin
      sync1 <= raw_n;
      sync2 <= sync1;
      sync3 <= sync2;
      pressed_q <= pressed;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_deb
      // Agreed level of the last two stages; only agreed changes count.
      wire stable = (sync2[gi] == sync3[gi]);
      wire low = ~sync3[gi];
      // Each filter keeps its own counter and level, so that every
      // variable has exactly one process driving it.
      reg [21:0] cnt;
      reg prs;
      assign pressed[gi] = prs;
      always @(posedge ref_clk) begin
        if (srst) begin
          cnt <= 22'h000000;
          prs <= 1'b0;
        end else if (!stable) begin
          cnt <= 22'h000000;
        end else if (low == prs) begin
          cnt <= 22'h000000;
        end else if (gi == 1 && !low) begin
          // The capture trigger is filtered on its press only, so that
          // recording stops the moment the switch opens.
          cnt <= 22'h000000;
          prs <= 1'b0;
        end else if (cnt >= DEB_CYCLES[21:0] - 22'h000001) begin
          cnt <= 22'h000000;
          prs <= low;
        end else begin
          cnt <= cnt + 22'h000001;
        end
      end
    end
  endgenerate

  // ***************************************************************
  // Message table, kept by the block itself
  // ***************************************************************
  // Start row of each message; the end of message i is start of i+1 minus one.
  reg [10:0] msg_start [0:`PBMC_MSG_MAX];
  reg [3:0] msg_count;
  reg [3:0] msg_ptr;
  reg [4:0] state;
  reg [26:0] tick_cnt;
  reg [27:0] hold_cnt;
  reg global_erase;
  reg loop_mode;
  reg int_pend;
  integer k;

  function is_edge_msg;
    input [3:0] ptr;
    input [3:0] cnt;
    begin
      is_edge_msg = (cnt != 4'h0) && (ptr == 4'h0 || ptr == cnt - 4'h1);
    end
  endfunction

  function [3:0] wrap_next;
    input [3:0] ptr;
    input [3:0] cnt;
    begin
      wrap_next = (cnt == 4'h0 || ptr + 4'h1 >= cnt) ? 4'h0 : ptr + 4'h1;
    end
  endfunction

  wire row_tick = (tick_cnt >= ROW_CYCLES[26:0] - 27'h0000001);
  wire [10:0] msg_end = msg_start[msg_ptr + 4'h1] - 11'h001;
  wire [10:0] free_row = msg_start[msg_count];
  wire pb_mode = ~serial_mode;

  always @(posedge ref_clk) begin
    if (srst) begin
      state <= ST_IDLE;
      msg_count <= 4'h0;
      msg_ptr <= 4'h0;
      row_addr <= `PBMC_MSG_FIRST;
      row_write <= 1'b0;
      row_erase <= 1'b0;
      audio_play <= 1'b0;
      audio_record <= 1'b0;
      tick_cnt <= 27'h0000000;
      hold_cnt <= 28'h0000000;
      global_erase <= 1'b0;
      loop_mode <= 1'b0;
      for (k = 0; k <= `PBMC_MSG_MAX; k = k + 1) begin
        msg_start[k] <= `PBMC_MSG_FIRST;
      end
    end else begin
      row_write <= 1'b0;
      row_erase <= 1'b0;
      tick_cnt <= row_tick ? 27'h0000000 : tick_cnt + 27'h0000001;
      case (state)
        ST_IDLE: begin
          tick_cnt <= 27'h0000000;
          audio_play <= 1'b0;
          audio_record <= 1'b0;
          if (!pb_mode) begin
            state <= ST_IDLE;
          end else if (press_edge[1] && msg_count < `PBMC_MSG_MAX && free_row <= LAST_ROW) begin
            // A full array refuses a new recording; otherwise the next
            // message would start past the last row and leave the array.
            // New messages are appended after the last one stored.
            state <= ST_REC;
            row_addr <= free_row;
            audio_record <= 1'b1;
          end else if (press_edge[0] && msg_count != 4'h0) begin
            state <= ST_PLAY;
            row_addr <= msg_start[msg_ptr];
            audio_play <= 1'b1;
            loop_mode <= 1'b0;
          end else if (press_edge[2]) begin
            state <= ST_ERASE;
            hold_cnt <= 28'h0000000;
            global_erase <= 1'b0;
          end else if (press_edge[3]) begin
            state <= ST_FWD;
            msg_ptr <= wrap_next(msg_ptr, msg_count);
          end
        end
        ST_REC: begin
          if (!pressed[1] || (row_tick && row_addr == LAST_ROW)) begin
            state <= ST_IDLE;
            audio_record <= 1'b0;
            msg_start[msg_count + 4'h1] <= row_addr + 11'h001;
            msg_count <= msg_count + 4'h1;
            msg_ptr <= msg_count;
          end else if (row_tick) begin
            row_write <= 1'b1;
            row_addr <= row_addr + 11'h001;
          end
        end
        ST_PLAY: begin
          if (pressed[0] && tick_cnt == 27'h0000000 && row_addr != msg_start[msg_ptr]) begin
            loop_mode <= 1'b1;
          end
          if (press_edge[3]) begin
            msg_ptr <= wrap_next(msg_ptr, msg_count);
            row_addr <= msg_start[wrap_next(msg_ptr, msg_count)];
            tick_cnt <= 27'h0000000;
          end else if (press_edge[0]) begin
            state <= ST_IDLE;
            audio_play <= 1'b0;
          end else if (row_tick && row_addr == msg_end) begin
            if (pressed[0] && loop_mode) begin
              msg_ptr <= wrap_next(msg_ptr, msg_count);
              row_addr <= msg_start[wrap_next(msg_ptr, msg_count)];
            end else begin
              state <= ST_IDLE;
              audio_play <= 1'b0;
            end
          end else if (row_tick) begin
            row_addr <= row_addr + 11'h001;
          end
        end
        ST_ERASE: begin
          if (pressed[2]) begin
            if (hold_cnt >= GERASE_CYCLES[27:0] - 28'h0000001) begin
              global_erase <= 1'b1;
            end else begin
              hold_cnt <= hold_cnt + 28'h0000001;
            end
          end else begin
            state <= ST_IDLE;
            row_erase <= global_erase || is_edge_msg(msg_ptr, msg_count);
            if (global_erase) begin
              msg_count <= 4'h0;
              msg_ptr <= 4'h0;
              row_addr <= `PBMC_MSG_FIRST;
            end else if (is_edge_msg(msg_ptr, msg_count)) begin
              // Only an end message is removed, so the table stays packed.
              row_addr <= msg_start[msg_ptr];
              if (msg_ptr == 4'h0) begin
                // The remaining messages keep their rows; only the table
                // moves down, so the freed rows at the front stay unused
                // until a reset, since a global erase leaves the start rows as they are.
                for (k = 0; k < `PBMC_MSG_MAX; k = k + 1) begin
                  msg_start[k] <= msg_start[k + 1];
                end
              end
              msg_count <= msg_count - 4'h1;
              msg_ptr <= (msg_ptr == 4'h0) ? 4'h0 : msg_ptr - 4'h1;
            end
          end
        end
        ST_FWD: begin
          if (!pressed[3]) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ***************************************************************
  // Ready / interrupt pin
  // ***************************************************************
  always @(posedge ref_clk) begin
    if (srst) begin
      int_pend <= 1'b0;
      ready_oe <= 1'b0;
      ready_o <= 1'b0;
    end else begin
      if (cmd_done) begin
        int_pend <= 1'b1;
      end else if (int_clear) begin
        int_pend <= 1'b0;
      end
      ready_o <= 1'b0;
      // In serial mode the pin follows the next value of the pending flag,
      // so a clear releases it at once and a completion still wins.
      ready_oe <= pb_mode ? (state != ST_IDLE) :
                  ((int_pend && !int_clear) || cmd_done);
    end
  end

endmodule

// *** sim/pbmc_switch.sv ***
`timescale 1ns/100ps
// ********************************
// Push switch with contact bounce
// ********************************
module pbmc_switch (
  input wire ref_clk,
  input wire press,
  output logic pin_n
);
  logic last = 1'b0;
  int bnc = 0;
  // Each edge chatters for two cycles; released, the pull-up holds the pin high.
  always @(posedge ref_clk) begin
    if (press != last) bnc <= 2;
    else if (bnc > 0) bnc <= bnc - 1;
    last <= press;
  end
  assign pin_n = (bnc > 0) ? bnc[0] : !last;
endmodule

// *** sim/pbmc_ctrl_assertions.sv ***
`timescale 1ns/100ps
// ***********
// Port checks
// ***********
module pbmc_ctrl_assertions #(
  parameter [10:0] LAST_ROW = 11'h0ff
) (
  input wire ref_clk,
  input wire srst,
  input wire serial_mode,
  input wire play_trigger_n,
  input wire capture_trigger_n,
  input wire erase_trigger_n,
  input wire skip_next_trigger_n,
  input wire cmd_done,
  input wire int_clear,
  input wire ready_oe,
  input wire ready_o,
  input wire [10:0] row_addr,
  input wire row_write,
  input wire row_erase,
  input wire audio_play,
  input wire audio_record
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence s_rec_rel;
    audio_record ##0 $rose(capture_trigger_n);
  endsequence
  sequence s_play_go;
    !audio_play ##1 audio_play && !serial_mode;
  endsequence
  AST_RDY_LOW: assert property (!ready_o)
    else $error("ready value high");
  AST_PLAY_BUSY: assert property (s_play_go |=> ready_oe)
    else $error("ready not busy in playback");
  AST_ROW_MAP: assert property (row_addr >= 11'h010 && row_addr <= LAST_ROW)
    else $error("row outside message area");
  AST_ONE_OP: assert property (!(audio_play && audio_record))
    else $error("play and record together");
  AST_REC_END: assert property (s_rec_rel |-> ##[1:6] !audio_record)
    else $error("record kept after release");
  AST_ROW_REC: assert property (row_write |-> audio_record || $past(audio_record))
    else $error("row written outside record");
  AST_INT_SET: assert property (serial_mode && cmd_done |=> ready_oe)
    else $error("no interrupt after command");
  AST_INT_CLR: assert property (serial_mode && int_clear && !cmd_done |=> !ready_oe)
    else $error("interrupt not cleared");
endmodule

bind pbmc_ctrl pbmc_ctrl_assertions #(.LAST_ROW(LAST_ROW)) i_pbmc_ctrl_assertions (
  .ref_clk(ref_clk), .srst(srst), .serial_mode(serial_mode),
  .play_trigger_n(play_trigger_n), .capture_trigger_n(capture_trigger_n),
  .erase_trigger_n(erase_trigger_n), .skip_next_trigger_n(skip_next_trigger_n),
  .cmd_done(cmd_done), .int_clear(int_clear), .ready_oe(ready_oe), .ready_o(ready_o),
  .row_addr(row_addr), .row_write(row_write), .row_erase(row_erase),
  .audio_play(audio_play), .audio_record(audio_record)
);

// *** sim/tb_pbmc_ctrl.sv ***
`timescale 1ns/100ps
// *****
// Bench
// *****
module tb_pbmc_ctrl;
  logic ref_clk = 0;
  logic srst = 1;
  logic serial_mode = 0;
  logic cmd_done = 0;
  logic int_clear = 0;
  logic pa = 0;
  logic [3:0] press = 0;
  logic [10:0] e;
  logic [10:0] pr = 11'h000;
  logic [31:0] lfsr = 32'h05d0b44f;
  wire [3:0] pin_n;
  wire [10:0] row_addr;
  wire ready_oe, ready_o, row_write, row_erase, audio_play, audio_record;
  int error_cnt = 0;
  int tests_run = 0;
  int rows = 0;
  int nr = 0;
  int c, p;
  int lens[$];
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    pa <= audio_play;
    pr <= row_addr;
    // Counts every message start during playback, looped ones included.
    if (audio_play === 1'b1 && (pa === 1'b0 || row_addr !== pr) && isst(row_addr)) nr <= nr + 1;
    if (row_write === 1'b1) rows <= rows + 1;
  end
  for (genvar g = 0; g < 4; g++) begin : g_sw
    pbmc_switch i_pbmc_switch (.ref_clk(ref_clk), .press(press[g]), .pin_n(pin_n[g]));
  end
  pbmc_ctrl #(.LAST_ROW(11'h03f), .DEB_CYCLES(4), .ROW_CYCLES(8), .GERASE_CYCLES(50))
  i_pbmc_ctrl (
    .ref_clk(ref_clk), .srst(srst), .serial_mode(serial_mode),
    .play_trigger_n(pin_n[0]), .capture_trigger_n(pin_n[1]),
    .erase_trigger_n(pin_n[2]), .skip_next_trigger_n(pin_n[3]),
    .cmd_done(cmd_done), .int_clear(int_clear), .ready_oe(ready_oe), .ready_o(ready_o),
    .row_addr(row_addr), .row_write(row_write), .row_erase(row_erase),
    .audio_play(audio_play), .audio_record(audio_record)
  );
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic mon(input int k);
    return k == 0 ? audio_play : k == 1 ? audio_record : k == 2 ? ready_oe : row_erase;
  endfunction
  // A played length may differ from eight cycles per recorded row by the row open at release and the start and stop latency.
  function automatic int fit(input int n);
    foreach (lens[i]) if (n > lens[i] * 8 - 10 && n < lens[i] * 8 + 10) return 1;
    return 0;
  endfunction
  // A message holds the rows written plus the row open at release.
  function automatic logic isst(input logic [10:0] a);
    int s = 16;
    foreach (lens[i]) begin
      if (a == s) return 1;
      s += lens[i] + 1;
    end
    return 0;
  endfunction
  task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s exp %0h seen %0h", n, exp, seen);
    end
  endtask
  task end_sim;
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task wt(input int k, input logic v, input int n, output int r);
    r = -1;
    for (int i = 0; i < n && r < 0; i++) begin
      cyc(1);
      if (mon(k) === v) r = i;
    end
  endtask
  task push(input int b, input int n);
    press[b] = 1;
    cyc(n);
    press[b] = 0;
  endtask
  initial begin
    cyc(20000);
    error_cnt++;
    end_sim;
  end
  initial begin
    cyc(10);
    srst = 0;
    chk("ready_oe", ready_oe, 0);
    chk("ready_o", ready_o, 0);
    chk("row_addr", row_addr, 11'h010);
    push(0, 1);
    wt(0, 1, 30, c);
    chk("glitch", c, -1);
    repeat (2) begin
      lfsr = nxt(lfsr);
      rows = 0;
      press[1] = 1;
      wt(1, 1, 20, c);
      chk("rec_on", c >= 0, 1);
      cyc(60 + lfsr[4:0]);
      press[1] = 0;
      wt(1, 0, 8, c);
      chk("rec_off", c >= 0, 1);
      cyc(10);
      lens.push_back(rows);
    end
    press[0] = 1;
    wt(0, 1, 20, c);
    chk("play_on", c >= 0, 1);
    press[0] = 0;
    wt(2, 1, 2, c);
    chk("busy", c >= 0, 1);
    wt(0, 0, 600, p);
    chk("play_len", fit(p), 1);
    cyc(2);
    chk("idle", ready_oe, 0);
    press[0] = 1;
    wt(0, 1, 20, c);
    press[0] = 0;
    cyc(12);
    press[0] = 1;
    wt(0, 0, 20, c);
    press[0] = 0;
    chk("stop", c >= 0, 1);
    cyc(20);
    nr = 0;
    press[0] = 1;
    cyc(lens[0] * 8 + lens[1] * 8 + 40);
    chk("loop", nr >= 2, 1);
    press[0] = 0;
    wt(0, 0, 300, c);
    chk("loop_end", c >= 0, 1);
    cyc(20);
    push(3, 12);
    cyc(10);
    chk("skip_idle", audio_play, 0);
    press[0] = 1;
    wt(0, 1, 20, c);
    press[0] = 0;
    e = (row_addr < 11'h010 + lens[0] + 1) ? 11'(11'h010 + lens[0] + 1) : 11'h010;
    push(3, 12);
    cyc(1);
    chk("skip_row", row_addr, e);
    wt(0, 0, 300, c);
    cyc(20);
    push(2, 10);
    wt(3, 1, 30, c);
    chk("erase", c >= 0, 1);
    press[2] = 1;
    cyc(80);
    press[2] = 0;
    cyc(30);
    press[0] = 1;
    wt(0, 1, 30, c);
    chk("gerase", c, -1);
    press[0] = 0;
    serial_mode = 1;
    cyc(20);
    press[1] = 1;
    wt(1, 1, 20, c);
    chk("serial_pin", c, -1);
    press[1] = 0;
    cmd_done = 1;
    cyc(1);
    cmd_done = 0;
    cyc(4);
    chk("int_set", ready_oe, 1);
    int_clear = 1;
    cyc(1);
    int_clear = 0;
    cyc(1);
    chk("int_clr", ready_oe, 0);
    end_sim;
  end
endmodule
